// file: logic/dbl_cfg.svh
/*
 * Constants for the burst, latency and recovery block: mode register
 * field positions, encodings and timing figures.
 * Assumes a 50 MHz clock and is included by the package and both ends.
 */
`ifndef DBL_CFG_SVH
`define DBL_CFG_SVH

// Clock period and timing figures
`define DBL_TCK_PS       20000
`define DBL_T_WR_NS      15
`define DBL_T_RTP_NS     8
`define DBL_T_RP_NS      15
`define DBL_CYC(ns)      (((ns) * 1000 + `DBL_TCK_PS - 1) / `DBL_TCK_PS)
`define DBL_TRP_CYC      `DBL_CYC(`DBL_T_RP_NS)
`define DBL_WR_MIN_CYC   `DBL_CYC(`DBL_T_WR_NS)
`define DBL_RTP_MIN_CYC  `DBL_CYC(`DBL_T_RTP_NS)
`define DBL_TDLLK        512
`define DBL_CWL          9

// Field encodings
`define DBL_WR_BASE      10
`define DBL_RTP_BASE     5
`define DBL_CL_BASE      9
`define DBL_CRC_WR_ADJ   2
`define DBL_CHOP_PULL    2
`define DBL_MIN_CODE(c, b) (((c) > (b)) ? ((c) - (b) + 1) / 2 : 0)
`define DBL_WR_MIN_CODE  3'(`DBL_MIN_CODE(`DBL_WR_MIN_CYC, `DBL_WR_BASE))
`define DBL_RTP_MIN_CODE 3'(`DBL_MIN_CODE(`DBL_RTP_MIN_CYC, `DBL_RTP_BASE))
`define DBL_BL_EIGHT     2'h0
`define DBL_BL_OTF       2'h1
`define DBL_BL_CHOP      2'h2
`define DBL_AL_M1        2'h1
`define DBL_AL_M2        2'h2
`define DBL_BT_INTL      1'h1

// Mode register selects
`define DBL_MR0          3'h0
`define DBL_MR1          3'h1
`define DBL_MR2          3'h2
`define DBL_MR5          3'h5

// Address bit positions
`define DBL_A_BL         1:0
`define DBL_A_BT         3
`define DBL_A_TM         7
`define DBL_A_DLLR       8
`define DBL_A_WR         11:9
`define DBL_A_CL4        12
`define DBL_A_CL31       6:4
`define DBL_A_CL0        2
`define DBL_A_AL         4:3
`define DBL_A_DLLEN      0
`define DBL_A_CRC        12
`define DBL_A_DM         10
`define DBL_A_CHOP       12
`define DBL_A_AP         10
`define DBL_A_HALF       2

// Beat slots and column count
`define DBL_LAST_BEAT    4'h7
`define DBL_CRC_SLOT     4'h8
`define DBL_CHOP_END     4'h4
`define DBL_COLS         64

`endif

// file: logic/dbl_pkg.sv
/*
 * Types and shared decoding for the burst, latency and recovery block.
 * Assumes dbl_cfg.svh on the include path.
 */
`include "dbl_cfg.svh"

package dbl_pkg;

	typedef enum logic [5:0] {
		cmd_nop = 6'h01,
		cmd_mrs = 6'h02,
		cmd_act = 6'h04,
		cmd_rd  = 6'h08,
		cmd_wr  = 6'h10,
		cmd_pre = 6'h20
	} dbl_cmd_t;

	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_dllr = 4'h2,
		st_xfer = 4'h4,
		st_gap  = 4'h8
	} dbl_ctl_st_t;

	// Column offset of beat i for a burst starting at st
	function automatic logic [2:0] burst_pos(input logic bt,
		input logic [2:0] st, input logic [2:0] i);
		logic [1:0] lo;
		lo = st[1:0] + i[1:0];
		burst_pos = (bt == `DBL_BT_INTL) ? (st ^ i) : {st[2] ^ i[2], lo};
	endfunction

	function automatic logic [6:0] cl_cycles(input logic [4:0] code);
		cl_cycles = 7'(code) + 7'(`DBL_CL_BASE);
	endfunction

	function automatic logic [6:0] al_cycles(input logic [1:0] al,
		input logic [6:0] cl);
		al_cycles = (al == `DBL_AL_M1) ? cl - 7'h01 :
			(al == `DBL_AL_M2) ? cl - 7'h02 : 7'h00;
	endfunction

	function automatic logic [7:0] wr_cycles(input logic [2:0] code);
		wr_cycles = 8'(`DBL_WR_BASE) + 8'({code, 1'b0});
	endfunction

	function automatic logic [7:0] rtp_cycles(input logic [2:0] code);
		rtp_cycles = 8'(`DBL_RTP_BASE) + 8'(code);
	endfunction

endpackage

// file: logic/dbl_link_if.sv
/*
 * Command, address and data link between controller and memory device.
 * Assumes both ends share clk; the data wire is resolved from enables.
 */
`timescale 1ns/1ps

interface dbl_link_if (
	input wire logic clk    // shared device clock
);
	dbl_pkg::dbl_cmd_t cmd;
	logic [13:0]       addr;
	logic [2:0]        mr_sel;
	logic [7:0]        ctl_dq;
	logic              ctl_dq_oe;
	logic [7:0]        dev_dq;
	logic              dev_dq_oe;
	logic              dev_dqs;
	logic              dev_dqs_oe;
	logic [7:0]        dq;

	// Wire level: device drive wins over controller drive, idle bus reads low
	assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : 8'h00);

	modport dev (input cmd, addr, mr_sel, dq,
		output dev_dq, dev_dq_oe, dev_dqs, dev_dqs_oe);
	modport ctl (output cmd, addr, mr_sel, ctl_dq, ctl_dq_oe,
		input dq, dev_dqs, dev_dqs_oe);
endinterface

// file: logic/dbl_mem_ctl.sv
/*
 * Controller end: issues mode register sets, column commands and data.
 * Assumes the device end on the same clock across dbl_link_if.
 */
`timescale 1ns/1ps
`include "dbl_cfg.svh"

module dbl_mem_ctl #(
	parameter int TDLLK = `DBL_TDLLK,  // DLL lock wait, cycles
	parameter int CWL   = `DBL_CWL     // CAS write latency
) (
	input  wire logic                clk,          // 50 MHz clock
	input  wire logic                reset_n,      // async reset
	input  wire logic                ce,           // freezes all state
	input  wire logic                req_valid,    // request present
	input  wire dbl_pkg::dbl_cmd_t   req_cmd,      // request command
	input  wire logic [13:0]         req_addr,     // address / MR bits
	input  wire logic [2:0]          req_mr_sel,   // mode register select
	input  wire logic [63:0]         req_wdata,    // write bytes, beat 0 low
	input  wire logic                req_bad_crc,  // corrupt the CRC beat
	output logic                     req_ready_q,  // request taken if valid
	output logic [63:0]              rd_data_q,    // read bytes in beat order
	output logic                     rd_valid_q,   // read burst done
	output logic                     dll_ready_q,  // DLL usable
	dbl_link_if.ctl                  lnk           // link to the device
);
	localparam int DW = $clog2(TDLLK + 1);

	if (TDLLK < 1 || CWL < 1 || CWL > 64)
	begin : g_chk
		$error("dbl_mem_ctl: TDLLK or CWL out of range");
	end

	dbl_pkg::dbl_ctl_st_t state_q;
	logic [13:0] mr0_q;
	logic [1:0]  bl_q;
	logic [1:0]  al_q;
	logic [4:0]  cl_code_q;
	logic        crc_q;
	logic        dm_q;
	logic        dll_en_q;
	logic [DW-1:0] dll_cnt_q;
	logic [7:0]  cnt_q;
	logic [3:0]  beat_q;
	logic        wr_q;
	logic        chop_q;
	logic        bad_q;
	logic [7:0]  csum_q;
	logic [63:0] wdata_q;
	logic [13:0] a0;
	logic [6:0]  cl;
	logic [6:0]  al;
	logic        take;
	logic        dllr_go;
	logic        byte_on;
	logic [2:0]  min_code;
	logic [7:0]  wbyte;

	// Sanitised MR0 image and current latencies
	always_comb
	begin
		min_code = (`DBL_WR_MIN_CODE > `DBL_RTP_MIN_CODE) ?
			`DBL_WR_MIN_CODE : `DBL_RTP_MIN_CODE;
		a0 = req_addr;
		a0[`DBL_A_TM] = 1'b0;
		if (a0[`DBL_A_WR] < min_code)
			a0[`DBL_A_WR] = min_code;
		cl = dbl_pkg::cl_cycles(cl_code_q);
		al = dbl_pkg::al_cycles(al_q, cl);
		take = req_valid && req_ready_q && state_q == dbl_pkg::st_idle;
		dllr_go = lnk.cmd == dbl_pkg::cmd_mrs && lnk.mr_sel == `DBL_MR0 &&
			lnk.addr[`DBL_A_DLLR];
		byte_on = !chop_q || beat_q < `DBL_CHOP_END;
		wbyte = wdata_q[{beat_q[2:0], 3'h0} +: 8];
	end

	// DLL wait: no reads until tDLLK after any reset issued
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dll_cnt_q   <= '0;
			dll_ready_q <= 1'b0;
		end
		else if (ce)
		begin
			if (dllr_go)
				dll_cnt_q <= DW'(TDLLK);
			else if (dll_cnt_q != '0)
				dll_cnt_q <= dll_cnt_q - 1'b1;
			// Held low until the pending DLL reset has gone out
			dll_ready_q <= dll_en_q && dll_cnt_q == '0 && !dllr_go &&
				state_q != dbl_pkg::st_dllr;
		end
	end

	// Request sequencer and link drive
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= dbl_pkg::st_idle;
			req_ready_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q <= '0;
			lnk.cmd <= dbl_pkg::cmd_nop;
			lnk.addr <= '0;
			lnk.mr_sel <= '0;
			lnk.ctl_dq <= '0;
			lnk.ctl_dq_oe <= 1'b0;
			mr0_q <= '0;
			bl_q <= `DBL_BL_EIGHT;
			al_q <= '0;
			cl_code_q <= '0;
			crc_q <= 1'b0;
			dm_q <= 1'b0;
			dll_en_q <= 1'b0;
			cnt_q <= '0;
			beat_q <= '0;
			wr_q <= 1'b0;
			chop_q <= 1'b0;
			bad_q <= 1'b0;
			csum_q <= '0;
			wdata_q <= '0;
		end
		else if (ce)
		begin
			lnk.cmd <= dbl_pkg::cmd_nop;
			lnk.ctl_dq_oe <= 1'b0;
			rd_valid_q <= 1'b0;
			req_ready_q <= state_q == dbl_pkg::st_idle && !take &&
				dll_cnt_q == '0 && !dllr_go;
			case (state_q)
				dbl_pkg::st_idle:
					if (take)
					begin
						lnk.cmd <= req_cmd;
						lnk.mr_sel <= req_mr_sel;
						lnk.addr <= req_addr;
						if (req_cmd == dbl_pkg::cmd_mrs)
						begin
							if (req_mr_sel == `DBL_MR0)
							begin
								lnk.addr <= a0;
								mr0_q <= a0;
								bl_q <= a0[`DBL_A_BL];
								cl_code_q <= {a0[`DBL_A_CL4], a0[`DBL_A_CL31],
									a0[`DBL_A_CL0]};
							end
							if (req_mr_sel == `DBL_MR1)
							begin
								al_q <= req_addr[`DBL_A_AL];
								dll_en_q <= req_addr[`DBL_A_DLLEN];
								if (req_addr[`DBL_A_DLLEN] && !dll_en_q)
									state_q <= dbl_pkg::st_dllr;
							end
							if (req_mr_sel == `DBL_MR2)
								crc_q <= req_addr[`DBL_A_CRC];
							if (req_mr_sel == `DBL_MR5)
								dm_q <= req_addr[`DBL_A_DM];
						end
						else if (req_cmd == dbl_pkg::cmd_rd ||
							req_cmd == dbl_pkg::cmd_wr)
						begin
							wr_q <= req_cmd == dbl_pkg::cmd_wr;
							chop_q <= bl_q == `DBL_BL_CHOP || (bl_q ==
								`DBL_BL_OTF && req_addr[`DBL_A_CHOP]);
							cnt_q <= req_cmd == dbl_pkg::cmd_wr ?
								8'(al) + 8'(CWL) - 8'h01 : 8'(al + cl) + 8'h01;
							beat_q <= '0;
							csum_q <= '0;
							bad_q <= req_bad_crc;
							wdata_q <= req_wdata;
							state_q <= dbl_pkg::st_xfer;
						end
					end
				dbl_pkg::st_dllr:
				begin
					lnk.cmd <= dbl_pkg::cmd_mrs;
					lnk.mr_sel <= `DBL_MR0;
					lnk.addr <= mr0_q | (14'h0001 << `DBL_A_DLLR);
					state_q <= dbl_pkg::st_idle;
				end
				dbl_pkg::st_xfer:
					if (cnt_q != 8'h00)
						cnt_q <= cnt_q - 8'h01;
					else
					begin
						beat_q <= beat_q + 4'h1;
						if (wr_q)
						begin
							lnk.ctl_dq_oe <= 1'b1;
							lnk.ctl_dq <= byte_on ? wbyte : 8'h00;
							if (beat_q == `DBL_CRC_SLOT)
								lnk.ctl_dq <= csum_q ^ {8{bad_q}};
							else if (byte_on)
								csum_q <= csum_q ^ wbyte;
							if (beat_q == ((crc_q && dm_q) ? `DBL_CRC_SLOT :
								`DBL_LAST_BEAT))
							begin
								cnt_q <= dbl_pkg::wr_cycles(mr0_q[`DBL_A_WR]) +
									8'(`DBL_TRP_CYC) +
									((crc_q && dm_q) ? 8'(`DBL_CRC_WR_ADJ)
									: 8'h00);
								state_q <= dbl_pkg::st_gap;
							end
						end
						else
						begin
							// Chopped slots read as zero, never stale bytes
							rd_data_q[{beat_q[2:0], 3'h0} +: 8] <=
								byte_on ? lnk.dq : 8'h00;
							if (beat_q == `DBL_LAST_BEAT)
							begin
								rd_valid_q <= 1'b1;
								cnt_q <= 8'h00;
								state_q <= dbl_pkg::st_gap;
							end
						end
					end
				dbl_pkg::st_gap:
					if (cnt_q != 8'h00)
						cnt_q <= cnt_q - 8'h01;
					else
						state_q <= dbl_pkg::st_idle;
				default:
					state_q <= dbl_pkg::st_idle;
			endcase
		end
	end
endmodule

// file: logic/dbl_mem_dev.sv
/*
 * Device end: mode register zero behaviour of the memory, burst order,
 * read latency, write CRC blocking, recovery timing and DLL reset.
 * Assumes a controller on the same clock across dbl_link_if; one beat
 * per clock, one burst in flight, one bank.
 */
`timescale 1ns/1ps
`include "dbl_cfg.svh"

module dbl_mem_dev #(
	parameter int TDLLK = `DBL_TDLLK,  // DLL lock wait, cycles
	parameter int CWL   = `DBL_CWL     // CAS write latency
) (
	input  wire logic clk,            // 50 MHz clock
	input  wire logic reset_n,        // async reset
	input  wire logic ce,             // freezes all state
	dbl_link_if.dev   lnk,            // link from the controller
	output logic      dll_locked_q,   // DLL locked, reads allowed
	output logic      crc_err_q,      // write dropped on CRC mismatch
	output logic      act_refused_q,  // activate during recovery
	output logic      rd_refused_q,   // read before DLL lock
	output logic      test_mode_q     // test-mode bit is set
);
	localparam int DW = $clog2(TDLLK + 1);

	if (TDLLK < 1 || CWL < 1 || CWL > 64)
	begin : g_chk
		$error("dbl_mem_dev: TDLLK or CWL out of range");
	end

	logic [7:0]    mem [`DBL_COLS];
	logic [7:0]    wbuf_q [8];
	logic [1:0]    bl_q;
	logic          bt_q;
	logic [4:0]    cl_code_q;
	logic [2:0]    wr_code_q;
	logic          dllr_q;
	logic [1:0]    al_q;
	logic          dll_en_q;
	logic          crc_en_q;
	logic          dm_en_q;
	logic [DW-1:0] dll_cnt_q;
	logic          act_q;
	logic          wr_q;
	logic          chop_q;
	logic          fixed_q;
	logic          ap_q;
	logic [2:0]    st_q;
	logic [2:0]    row_q;
	logic [6:0]    cnt_q;
	logic [3:0]    beat_q;
	logic [7:0]    csum_q;
	logic          commit_q;
	logic [7:0]    rec_q;
	logic [6:0]    cl;
	logic [6:0]    al;
	logic          col_cmd;
	logic          is_rd;
	logic          chop_cmd;
	logic          crc_on;
	logic          slot;
	logic          start;
	logic          cap;
	logic          drive;
	logic [3:0]    last;

	// Latencies and command decode
	always_comb
	begin
		cl = dbl_pkg::cl_cycles(cl_code_q);
		al = dbl_pkg::al_cycles(al_q, cl);
		is_rd = lnk.cmd == dbl_pkg::cmd_rd;
		col_cmd = is_rd || lnk.cmd == dbl_pkg::cmd_wr;
		chop_cmd = bl_q == `DBL_BL_CHOP ||
			(bl_q == `DBL_BL_OTF && lnk.addr[`DBL_A_CHOP]);
		crc_on = crc_en_q && dm_en_q;
		slot = act_q && cnt_q == 7'h00;
		start = col_cmd && !act_q && (!is_rd || dll_locked_q);
		cap = slot && wr_q && beat_q < `DBL_CRC_SLOT &&
			(!chop_q || beat_q < `DBL_CHOP_END);
		drive = slot && !wr_q && (!chop_q || beat_q < `DBL_CHOP_END);
		last = (wr_q && crc_on) ? `DBL_CRC_SLOT : `DBL_LAST_BEAT;
	end

	// Mode register capture; later commands use these until rewritten
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bl_q <= `DBL_BL_EIGHT;
			bt_q <= 1'b0;
			cl_code_q <= '0;
			test_mode_q <= 1'b0;
			wr_code_q <= '0;
			dllr_q <= 1'b0;
			al_q <= '0;
			dll_en_q <= 1'b0;
			crc_en_q <= 1'b0;
			dm_en_q <= 1'b0;
		end
		else if (ce)
		begin
			dllr_q <= 1'b0;
			if (lnk.cmd == dbl_pkg::cmd_mrs)
			begin
				if (lnk.mr_sel == `DBL_MR0)
				begin
					bl_q <= lnk.addr[`DBL_A_BL];
					bt_q <= lnk.addr[`DBL_A_BT];
					cl_code_q <= {lnk.addr[`DBL_A_CL4], lnk.addr[`DBL_A_CL31],
						lnk.addr[`DBL_A_CL0]};
					test_mode_q <= lnk.addr[`DBL_A_TM];
					wr_code_q <= lnk.addr[`DBL_A_WR];
					dllr_q <= lnk.addr[`DBL_A_DLLR];
				end
				else if (lnk.mr_sel == `DBL_MR1)
				begin
					al_q <= lnk.addr[`DBL_A_AL];
					dll_en_q <= lnk.addr[`DBL_A_DLLEN];
				end
				else if (lnk.mr_sel == `DBL_MR2)
					crc_en_q <= lnk.addr[`DBL_A_CRC];
				else if (lnk.mr_sel == `DBL_MR5)
					dm_en_q <= lnk.addr[`DBL_A_DM];
			end
		end
	end

	// DLL lock wait, restarted by every reset request
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dll_cnt_q <= '0;
			dll_locked_q <= 1'b0;
		end
		else if (ce)
		begin
			if (dllr_q)
				dll_cnt_q <= DW'(TDLLK);
			else if (dll_cnt_q != '0)
				dll_cnt_q <= dll_cnt_q - 1'b1;
			dll_locked_q <= dll_en_q && dll_cnt_q == '0 && !dllr_q;
		end
	end

	// Burst sequencer: waits the latency, then steps the beat slots
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			act_q <= 1'b0;
			wr_q <= 1'b0;
			chop_q <= 1'b0;
			fixed_q <= 1'b0;
			ap_q <= 1'b0;
			st_q <= '0;
			row_q <= '0;
			cnt_q <= '0;
			beat_q <= '0;
			csum_q <= '0;
			commit_q <= 1'b0;
			crc_err_q <= 1'b0;
			rd_refused_q <= 1'b0;
		end
		else if (ce)
		begin
			commit_q <= 1'b0;
			crc_err_q <= 1'b0;
			// Reads before lock would break output timing, so drop them
			rd_refused_q <= is_rd && !act_q && !dll_locked_q;
			if (start)
			begin
				act_q <= 1'b1;
				wr_q <= !is_rd;
				chop_q <= chop_cmd;
				fixed_q <= bl_q == `DBL_BL_CHOP;
				ap_q <= lnk.addr[`DBL_A_AP];
				st_q <= lnk.addr[2:0];
				row_q <= lnk.addr[5:3];
				cnt_q <= is_rd ? al + cl - 7'h01 :
					al + 7'(CWL) - 7'h01;
				beat_q <= '0;
				csum_q <= '0;
			end
			else if (act_q && cnt_q != 7'h00)
				cnt_q <= cnt_q - 7'h01;
			else if (slot)
			begin
				beat_q <= beat_q + 4'h1;
				if (cap)
					csum_q <= csum_q ^ lnk.dq;
				if (beat_q == last)
				begin
					act_q <= 1'b0;
					if (wr_q && crc_on && lnk.dq != csum_q)
						crc_err_q <= 1'b1;
					else if (wr_q)
						commit_q <= 1'b1;
				end
			end
		end
	end

	// Write buffer and array commit; data storage needs no reset
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			if (cap)
				wbuf_q[beat_q[2:0]] <= lnk.dq;
			if (commit_q)
			begin
				for (int i = 0; i < 8; i++)
				begin
					if (!chop_q)
						mem[{row_q, 3'(i)}] <= wbuf_q[i];
					else if (i < 4)
						mem[{row_q, st_q[`DBL_A_HALF], 2'(i)}] <= wbuf_q[i];
				end
			end
		end
	end

	// Read drive; strobe toggles per beat, both off outside beats
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lnk.dev_dq <= '0;
			lnk.dev_dq_oe <= 1'b0;
			lnk.dev_dqs <= 1'b0;
			lnk.dev_dqs_oe <= 1'b0;
		end
		else if (ce)
		begin
			lnk.dev_dq <= mem[{row_q,
				dbl_pkg::burst_pos(bt_q, st_q, beat_q[2:0])}];
			lnk.dev_dq_oe <= drive;
			lnk.dev_dqs_oe <= drive;
			lnk.dev_dqs <= drive ? !lnk.dev_dqs : 1'b0;
		end
	end

	// Bank recovery after auto precharge; an activate during it is only flagged
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rec_q <= '0;
			act_refused_q <= 1'b0;
		end
		else if (ce)
		begin
			if (commit_q && ap_q)
				rec_q <= dbl_pkg::wr_cycles(wr_code_q) +
					8'(`DBL_TRP_CYC) +
					(crc_on ? 8'(`DBL_CRC_WR_ADJ) : 8'h00) -
					(fixed_q ? 8'(`DBL_CHOP_PULL) : 8'h00);
			else if (start && is_rd && lnk.addr[`DBL_A_AP])
				rec_q <= 8'(al) + dbl_pkg::rtp_cycles(wr_code_q) +
					8'(`DBL_TRP_CYC);
			else if (rec_q != 8'h00)
				rec_q <= rec_q - 8'h01;
			act_refused_q <= lnk.cmd == dbl_pkg::cmd_act && rec_q != 8'h00;
		end
	end
endmodule

// file: sim/dbl_link_monitor.sv
/*
 * Link monitor: latency, burst shape and mode-set checks on the link.
 * Assumes the bench places it beside the link, on the shared clock.
 */
`timescale 1ns/1ps
`include "dbl_cfg.svh"

module dbl_link_monitor #(
	parameter int CWL = `DBL_CWL  // CAS write latency
) (
	input wire logic              clk,        // shared clock
	input wire logic              reset_n,    // async reset
	input wire dbl_pkg::dbl_cmd_t cmd,        // link command
	input wire logic [13:0]       addr,       // link address
	input wire logic [2:0]        mr_sel,     // mode register select
	input wire logic              ctl_dq_oe,  // controller drive
	input wire logic              dev_dq_oe,  // device data drive
	input wire logic              dev_dqs,    // read strobe
	input wire logic              dev_dqs_oe  // strobe drive
);
	logic [4:0] cl_code_q;
	logic [1:0] al_q;
	logic [1:0] bl_q;
	logic [7:0] rd_cnt_q;
	logic [7:0] wr_cnt_q;
	logic [7:0] cl;
	logic [7:0] al;
	logic       is_mr0;

	// Latency as the device should hold it after the last mode sets
	assign is_mr0 = cmd == dbl_pkg::cmd_mrs && mr_sel == `DBL_MR0;
	assign cl = 8'(cl_code_q) + 8'(`DBL_CL_BASE);
	assign al = (al_q == `DBL_AL_M1) ? cl - 8'h01 :
		(al_q == `DBL_AL_M2) ? cl - 8'h02 : 8'h00;

	// Shadow of mode fields, taken from every MR0 and MR1 mode set
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cl_code_q <= 5'h00;
			bl_q      <= 2'h0;
			al_q      <= 2'h0;
		end
		else if (cmd == dbl_pkg::cmd_mrs && mr_sel == `DBL_MR1)
			al_q <= addr[`DBL_A_AL];
		else if (is_mr0)
		begin
			cl_code_q <= {addr[12], addr[6:4], addr[2]};
			bl_q      <= addr[`DBL_A_BL];
		end
	end

	// Cycles since the last read and since the last write; saturates, never wraps
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_cnt_q <= 8'hFF;
			wr_cnt_q <= 8'hFF;
		end
		else
		begin
			rd_cnt_q <= (cmd == dbl_pkg::cmd_rd) ? 8'h01 :
				rd_cnt_q + 8'(rd_cnt_q != 8'hFF);
			wr_cnt_q <= (cmd == dbl_pkg::cmd_wr) ? 8'h01 :
				wr_cnt_q + 8'(wr_cnt_q != 8'hFF);
		end
	end

	sequence s_four_on;
		dev_dq_oe [*4];
	endsequence
	sequence s_four_off;
		!dev_dq_oe [*4];
	endsequence

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	chk_no_test_mode: assert property (is_mr0 |-> !addr[`DBL_A_TM])
		else $error("test-mode bit set on the link");
	chk_wr_at_min: assert property
		(is_mr0 |-> addr[`DBL_A_WR] >= `DBL_WR_MIN_CODE)
		else $error("write recovery below minimum");
	chk_rtp_at_min: assert property
		(is_mr0 |-> addr[`DBL_A_WR] >= `DBL_RTP_MIN_CODE)
		else $error("read to precharge below minimum");
	chk_read_lat_sum: assert property
		($rose(dev_dq_oe) |-> rd_cnt_q == al + cl + 8'h01)
		else $error("read data not at additive plus CAS latency");
	chk_write_lat_sum: assert property
		($rose(ctl_dq_oe) |-> wr_cnt_q == al + 8'(CWL))
		else $error("write data not at write latency");
	chk_chop_read_off: assert property
		($rose(dev_dq_oe) && bl_q == `DBL_BL_CHOP |-> s_four_on ##1 s_four_off)
		else $error("chopped read not four beats then off");
	chk_full_read_len: assert property
		($rose(dev_dq_oe) && bl_q == `DBL_BL_EIGHT
		|-> s_four_on ##1 s_four_on ##1 !dev_dq_oe)
		else $error("full read not eight beats");
	chk_strobe_with_dq: assert property (dev_dqs_oe == dev_dq_oe)
		else $error("strobe drive differs from data drive");
	chk_strobe_toggle: assert property
		(dev_dqs_oe && $past(dev_dqs_oe) |-> dev_dqs != $past(dev_dqs))
		else $error("strobe did not toggle between beats");
endmodule

// file: sim/testbench.sv
/*
 * Bench for both link ends: burst order, latency, CRC, DLL wait.
 * Assumes the logic files are compiled first; runs stand-alone.
 */
`timescale 1ns/1ps
`include "dbl_cfg.svh"

module testbench;
	typedef struct {
		logic [13:0] mr0;   // mode register zero value
		logic [13:0] ra;    // read address
		logic [31:0] ord;   // column per beat, beat 0 on top
		logic        chop;  // four beats only
		int          lat;   // take to read done, cycles
	} dbl_row_t;

	logic              clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              req_valid = 1'b0;
	dbl_pkg::dbl_cmd_t req_cmd = dbl_pkg::cmd_nop;
	logic [13:0]       req_addr = 14'h0000;
	logic [2:0]        req_mr_sel = 3'h0;
	logic [63:0]       req_wdata = 64'h0;
	logic              req_bad_crc = 1'b0;
	logic              req_ready_q, rd_valid_q, dll_ready_q;
	logic [63:0]       rd_data_q;
	logic              dll_locked_q, crc_err_q, act_refused_q;
	logic              rd_refused_q, test_mode_q;
	int                err_count = 0;
	int                checks = 0;
	int                crc_seen = 0;
	int                refused_seen = 0;
	int                act_seen = 0;
	int                n;
	// Seq, interleaved, fixed chop and on-the-fly, several latencies
	dbl_row_t rows [6] = '{
		'{14'h0000, 14'h0005, 32'h56741230, 1'b0, 18},
		'{14'h000C, 14'h0003, 32'h32107654, 1'b0, 19},
		'{14'h0002, 14'h0006, 32'h67450000, 1'b1, 18},
		'{14'h000A, 14'h0001, 32'h10320000, 1'b1, 18},
		'{14'h0001, 14'h1002, 32'h23010000, 1'b1, 18},
		'{14'h0019, 14'h0007, 32'h76543210, 1'b0, 20}};

	always #10 clk = ~clk;

	dbl_link_if lnk (.clk(clk));
	dbl_mem_ctl #(.TDLLK(4), .CWL(`DBL_CWL)) dbl_mem_ctl_i (.clk(clk),
		.reset_n(reset_n), .ce(1'b1), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_addr(req_addr), .req_mr_sel(req_mr_sel),
		.req_wdata(req_wdata), .req_bad_crc(req_bad_crc),
		.req_ready_q(req_ready_q), .rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q), .dll_ready_q(dll_ready_q), .lnk(lnk));
	dbl_mem_dev #(.TDLLK(4), .CWL(`DBL_CWL)) dbl_mem_dev_i (.clk(clk),
		.reset_n(reset_n), .ce(1'b1), .lnk(lnk),
		.dll_locked_q(dll_locked_q), .crc_err_q(crc_err_q),
		.act_refused_q(act_refused_q), .rd_refused_q(rd_refused_q),
		.test_mode_q(test_mode_q));
	dbl_link_monitor #(.CWL(`DBL_CWL)) dbl_link_monitor_i (.clk(clk),
		.reset_n(reset_n), .cmd(lnk.cmd), .addr(lnk.addr),
		.mr_sel(lnk.mr_sel), .ctl_dq_oe(lnk.ctl_dq_oe),
		.dev_dq_oe(lnk.dev_dq_oe), .dev_dqs(lnk.dev_dqs),
		.dev_dqs_oe(lnk.dev_dqs_oe));

	// Pulses counted at the falling edge, away from the launch edge
	always @(negedge clk)
	begin
		if (crc_err_q === 1'b1)
			crc_seen++;
		if (rd_refused_q === 1'b1)
			refused_seen++;
		if (act_refused_q === 1'b1)
			act_seen++;
	end

	task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_count(input int got, input int exp);
		checks++;
		if (got != exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held from a falling edge until the taking rising edge
	task automatic send(input dbl_pkg::dbl_cmd_t c, input logic [2:0] sel,
		input logic [13:0] a, input logic [63:0] d);
		int k;
		k = 0;
		while (req_ready_q !== 1'b1 && k < 2000)
		begin
			@(negedge clk);
			k++;
		end
		req_valid = 1'b1;
		req_cmd = c;
		req_mr_sel = sel;
		req_addr = a;
		req_wdata = d;
		@(negedge clk);
		req_valid = 1'b0;
	endtask

	task automatic rd_check(input logic [13:0] a, input logic [63:0] exp,
		input int lat);
		int k;
		send(dbl_pkg::cmd_rd, 3'h0, a, 64'h0);
		k = 0;
		while (rd_valid_q !== 1'b1 && k < 300)
		begin
			@(negedge clk);
			k++;
		end
		cmp_count(k, lat);
		cmp_data(rd_data_q, exp);
	endtask

	function automatic logic [63:0] exp_of(input logic [31:0] ord,
		input logic chop);
		logic [63:0] v;
		v = 64'h0;
		for (int i = 0; i < 8; i++)
			if (!(chop && i > 3))
				v[i*8 +: 8] = 8'hA0 + 8'(ord[28 - i*4 +: 4]);
		return v;
	endfunction

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		cmp_data(64'({req_ready_q, dll_ready_q, rd_valid_q, lnk.cmd}), 64'h1);
		@(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		send(dbl_pkg::cmd_mrs, `DBL_MR0, 14'h0000, 64'h0);
		// Read with the DLL off: device drops it, bus reads as zero
		rd_check(14'h0000, 64'h0, 18);
		cmp_count(refused_seen, 1);
		send(dbl_pkg::cmd_mrs, `DBL_MR1, 14'h0001, 64'h0);
		n = 0;
		while (dll_ready_q !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		cmp_count(int'(n >= 4), 1);
		// Device locks one clock after the controller's own count
		@(negedge clk);
		cmp_data(64'(dll_locked_q), 64'h1);
		send(dbl_pkg::cmd_mrs, `DBL_MR0, 14'h0080, 64'h0);
		repeat (3) @(negedge clk);
		cmp_data(64'(test_mode_q), 64'h0);
		$display("Reset and DLL lock done");
		send(dbl_pkg::cmd_wr, 3'h0, 14'h0000, 64'hA7A6A5A4A3A2A1A0);
		foreach (rows[r])
		begin
			send(dbl_pkg::cmd_mrs, `DBL_MR0, rows[r].mr0, 64'h0);
			rd_check(rows[r].ra, exp_of(rows[r].ord, rows[r].chop),
				rows[r].lat);
		end
		$display("Burst table done");
		// Chopped write: low bits ignored, A2 picks the upper half
		send(dbl_pkg::cmd_mrs, `DBL_MR0, 14'h0001, 64'h0);
		send(dbl_pkg::cmd_wr, 3'h0, 14'h1007, 64'h00000000B3B2B1B0);
		send(dbl_pkg::cmd_mrs, `DBL_MR0, 14'h0000, 64'h0);
		rd_check(14'h0000, 64'hB3B2B1B0A3A2A1A0, 18);
		send(dbl_pkg::cmd_mrs, `DBL_MR1, 14'h0009, 64'h0);
		rd_check(14'h0000, 64'hB3B2B1B0A3A2A1A0, 26);
		send(dbl_pkg::cmd_mrs, `DBL_MR1, 14'h0001, 64'h0);
		$display("Chopped write and additive latency done");
		send(dbl_pkg::cmd_mrs, `DBL_MR2, 14'h1000, 64'h0);
		send(dbl_pkg::cmd_mrs, `DBL_MR5, 14'h0400, 64'h0);
		req_bad_crc = 1'b1;
		send(dbl_pkg::cmd_wr, 3'h0, 14'h0000, 64'hFFEEDDCCBBAA9988);
		rd_check(14'h0000, 64'hB3B2B1B0A3A2A1A0, 18);
		cmp_count(crc_seen, 1);
		req_bad_crc = 1'b0;
		send(dbl_pkg::cmd_wr, 3'h0, 14'h0000, 64'h1122334455667788);
		rd_check(14'h0000, 64'h1122334455667788, 18);
		cmp_count(crc_seen, 1);
		rd_check(14'h0400, 64'h1122334455667788, 18);
		send(dbl_pkg::cmd_act, 3'h0, 14'h0000, 64'h0);
		repeat (2) @(negedge clk);
		cmp_count(act_seen, 0);
		$display("Write CRC blocking done");
		complete_run();
	end

	// Watchdog far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		complete_run();
	end
endmodule
